// ---- verilog/ccr_params.svh ----
// Constants of the charger configuration register bank.
// Included by the package and by every design file; definitions only.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Bus address of the slave, seven bits
`define CCR_I2C_ADDR        7'h1a

// Register indices
`define CCR_ADDR_INPUT_SRC  8'h00
`define CCR_ADDR_CHG_EN     8'h01
`define CCR_ADDR_CHG_CUR    8'h02
`define CCR_ADDR_FAULT      8'h09
`define CCR_ADDR_FLAG       8'h0e
`define CCR_ADDR_LAST       8'h0f

// Power-on values
`define CCR_POWER_ON_VALUE_INPUT_SRC  8'h17
`define CCR_POWER_ON_VALUE_CHG_EN     8'h1a
`define CCR_POWER_ON_VALUE_CHG_CUR    8'hb4

// Fields that the watchdog expiry also returns to power-on value
`define CCR_WDM_INPUT_SRC   8'h80
`define CCR_WDM_CHG_EN      8'h70
`define CCR_WDM_CHG_CUR     8'hbf

// Read answers
`define CCR_RD_BEYOND       8'hff
`define CCR_RD_UNHELD       8'h00

// Field positions, input source control
`define CCR_BIT_FLOAT       7
`define CCR_POS_IND_HI      6
`define CCR_POS_IND_LO      5
`define CCR_POS_ILIM_HI     4
`define CCR_POS_ILIM_LO     0
// Field positions, charge enable control
`define CCR_BIT_LLM_DIS     7
`define CCR_BIT_KICK        6
`define CCR_BIT_BOOST       5
`define CCR_BIT_CHG         4
`define CCR_POS_SYSV_HI     3
`define CCR_POS_SYSV_LO     1
`define CCR_BIT_LOWBAT      0
// Field positions, charge current control
`define CCR_BIT_BLIM        7
`define CCR_BIT_FULLDRV     6
`define CCR_POS_FAST_CHARGE_CURRENT_CODE_HI     5
`define CCR_POS_FAST_CHARGE_CURRENT_CODE_LO     0

// Limit codes below this use the higher switch resistance (700 mA)
`define CCR_ILIM_FULL_CODE  5'h06

`endif

// ---- verilog/ccr_pkg.sv ----
// Types of the charger configuration register bank.
// Assumes ccr_params.svh is on the include path.
`include "ccr_params.svh"

package ccr_pkg;

	// Serial slave states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_ADDR     = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_REG      = 9'h008,
		ST_REG_ACK  = 9'h010,
		ST_WDATA    = 9'h020,
		ST_WACK     = 9'h040,
		ST_RDATA    = 9'h080,
		ST_RACK     = 9'h100
	} ccr_state_e;

	// Settings handed to the power stage
	typedef struct packed {
		logic        input_float_mode;
		logic [1:0]  indicator_pin_function;
		logic [4:0]  input_current_limit;
		logic        light_load_mod_disable;
		logic        boost_output_enable;
		logic        charge_active;
		logic [2:0]  system_voltage_floor;
		logic        boost_low_battery_select;
		logic        boost_current_limit;
		logic        input_switch_full_drive;
		logic [11:0] fast_charge_current_ma;
	} ccr_ctrl_s;

	// Conditioned bus pin events
	typedef struct packed {
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} ccr_bus_s;

endpackage : ccr_pkg

// ---- verilog/ccr_i2c_sync.sv ----
// Pin conditioner for the serial bus: synchronises both lines and
// reports clock edges, start and stop. Assumes lines idle high.
`timescale 1ns/1ns
`include "ccr_params.svh"

module ccr_i2c_sync (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Raw bus lines
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	// Conditioned events
	output ccr_pkg::ccr_bus_s      bus_o
);

	logic [1:0] scl_sy_r;   // Two-flop synchroniser, clock line
	logic [1:0] sda_sy_r;   // Two-flop synchroniser, data line
	logic       scl_d_r;    // Previous synchronised clock
	logic       sda_d_r;    // Previous synchronised data

	// Edge and condition detection reads only the second stage
	wire scl_now = scl_sy_r[1];
	wire sda_now = sda_sy_r[1];
	wire rise_w  = scl_now & ~scl_d_r;
	wire fall_w  = ~scl_now & scl_d_r;
	wire start_w = scl_now & scl_d_r & sda_d_r & ~sda_now;
	wire stop_w  = scl_now & scl_d_r & ~sda_d_r & sda_now;

	// Synchronisers; reset to the idle-high bus level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end
		else
		begin
			scl_sy_r <= {scl_sy_r[0], scl_i};
			sda_sy_r <= {sda_sy_r[0], sda_i};
			scl_d_r  <= scl_now;
			sda_d_r  <= sda_now;
		end
	end

	// Registered events, all aligned with each other
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bus_o <= '{sda: 1'b1, scl_rise: 1'b0, scl_fall: 1'b0, start: 1'b0, stop: 1'b0};
		else
			bus_o <= '{sda: sda_now, scl_rise: rise_w, scl_fall: fall_w,
			           start: start_w, stop: stop_w};
	end

endmodule : ccr_i2c_sync

// ---- verilog/ccr_bank.sv ----
// Charger configuration register bank, registers 0x00 to 0x02, with
// its serial slave. Assumes open-drain lines resolved outside, and
// source detection, watchdog and register-reset logic on clk.
//
// How it works
// - All registers are eight bits, bit 0 lowest.
// - Slave answers only at seven-bit address 0x1A.
// - Register 0x00 powers up as 00010111.
// - Register 0x01 powers up as 00011010.
// - Register 0x02 powers up as 10110100.
// - Bit 7 of 0x00 floats the input.
// - Bits 6:5 of 0x00 pick indicator function.
// - Bits 4:0 of 0x00 set input limit.
// - Source detection loads limit; host writes after.
// - Bit 7 of 0x01 disables light-load modulation.
// - Writing kick bit restarts the watchdog.
// - Kick bit self-clears after restart or expiry.
// - Boost enable bit overrides charge enable.
// - Charging needs bit and low enable pin.
// - Bits 3:1 of 0x01 pick system floor.
// - Bit 7 of 0x02 picks boost limit.
// - Cleared bit 6 uses high resistance below 700mA unless boost is on.
// - Bits 5:0 of 0x02 map charge current table.
// - Reads beyond 0x0F return 0xFF.
// - Burst access steps address, skipping 0x09, 0x0E.
`timescale 1ns/1ns
`include "ccr_params.svh"

module ccr_bank (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Serial bus pins, data line open drain
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	// Charge enable pin, active low, asynchronous
	input  wire logic              charge_enable_pin_low_n,
	// Source detection, same clock
	input  wire logic              detect_busy,
	input  wire logic              detect_done,
	input  wire logic [4:0]        detect_limit,
	// Watchdog and register reset, same clock
	input  wire logic              watchdog_expired,
	input  wire logic              reg_reset_cmd,
	output logic                   watchdog_restart,
	// Settings to the power stage
	output ccr_pkg::ccr_ctrl_s     ctrl_o
);

	// Next pointer in a burst, stepping over fault and flag registers
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		logic [7:0] n;
		n = p + 8'h01;
		if (n == `CCR_ADDR_FAULT || n == `CCR_ADDR_FLAG)
			n = n + 8'h01;
		return n;
	endfunction : next_ptr

	// Piecewise charge current table, result in milliamps
	function automatic logic [11:0] fast_charge_current_code_ma(input logic [5:0] c);
		logic [11:0] k;
		k = {6'h00, c};
		if (c < 6'h08)
			return 12'(k * 12'h005);
		else if (c < 6'h10)
			return 12'(12'h028 + (k - 12'h008) * 12'h00a);
		else if (c < 6'h18)
			return 12'(12'h082 + (k - 12'h010) * 12'h014);
		else if (c < 6'h20)
			return 12'(12'h12c + (k - 12'h018) * 12'h01e);
		else if (c < 6'h30)
			return 12'(12'h21c + (k - 12'h020) * 12'h03c);
		else if (c < 6'h3d)
			return 12'(12'h5dc + (k - 12'h030) * 12'h078);
		else
			return 12'hbb8;
	endfunction : fast_charge_current_code_ma

	// Watchdog subset returns to power-on value, the rest stays
	function automatic logic [7:0] wd_clean(input logic [7:0] v,
	                                        input logic [7:0] power_on_value,
	                                        input logic [7:0] mask);
		return (v & ~mask) | (power_on_value & mask);
	endfunction : wd_clean

	ccr_pkg::ccr_bus_s  bus;          // Conditioned bus events
	ccr_pkg::ccr_state_e state_r;     // Slave state
	ccr_pkg::ccr_state_e state_nxt;   // Next slave state
	logic [7:0] src_r;                // Input source control
	logic [7:0] chg_r;                // Charge enable control
	logic [7:0] cur_r;                // Charge current control
	logic [7:0] shift_r;              // Receive shifter
	logic [7:0] tx_r;                 // Transmit shifter
	logic [7:0] ptr_r;                // Register pointer
	logic [3:0] bit_cnt_r;            // Bits seen in this byte
	logic       rw_r;                 // Read transfer when set
	logic [1:0] ce_sy_r;              // Enable pin synchroniser
	logic       sda_oe_nxt;           // Next data line pull-down

	// Pin conditioner
	ccr_i2c_sync u_sync (
		.clk   (clk),
		.rst   (rst),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.bus_o (bus)
	);

	// Byte boundaries of the slave
	wire byte_done = bus.scl_fall & (bit_cnt_r == 4'h8);
	wire addr_hit  = (shift_r[7:1] == `CCR_I2C_ADDR);
	wire in_rx     = (state_r == ccr_pkg::ST_ADDR) | (state_r == ccr_pkg::ST_REG) |
	                 (state_r == ccr_pkg::ST_WDATA);
	wire wr_stb    = (state_r == ccr_pkg::ST_WDATA) & byte_done;
	wire rack_ok   = (state_r == ccr_pkg::ST_RACK) & bus.scl_rise & ~bus.sda;

	// Read multiplexer
	wire       ptr_beyond = (ptr_r > `CCR_ADDR_LAST);
	wire [7:0] rd_held = (ptr_r == `CCR_ADDR_INPUT_SRC) ? src_r :
	                     (ptr_r == `CCR_ADDR_CHG_EN)    ? chg_r :
	                     (ptr_r == `CCR_ADDR_CHG_CUR)   ? cur_r : `CCR_RD_UNHELD;
	wire [7:0] rd_byte = ptr_beyond ? `CCR_RD_BEYOND : rd_held;

	// Write strobes per register
	wire wr_src = wr_stb & (ptr_r == `CCR_ADDR_INPUT_SRC);
	wire wr_chg = wr_stb & (ptr_r == `CCR_ADDR_CHG_EN);
	wire wr_cur = wr_stb & (ptr_r == `CCR_ADDR_CHG_CUR);

	// Watchdog stage of the next values
	wire [7:0] src_wd = watchdog_expired ?
	                    wd_clean(src_r, `CCR_POWER_ON_VALUE_INPUT_SRC, `CCR_WDM_INPUT_SRC) : src_r;
	wire [7:0] cur_wd = watchdog_expired ?
	                    wd_clean(cur_r, `CCR_POWER_ON_VALUE_CHG_CUR, `CCR_WDM_CHG_CUR) : cur_r;
	wire [7:0] chg_wd = watchdog_expired ?
	                    wd_clean(chg_r, `CCR_POWER_ON_VALUE_CHG_EN, `CCR_WDM_CHG_EN) : chg_r;

	// Kick bit drops once the restart pulse has gone out
	wire [7:0] chg_kc = watchdog_restart ? (chg_wd & ~(8'h01 << `CCR_BIT_KICK)) : chg_wd;

	// Host write stage; limit field is held while detection runs
	wire [4:0] ilim_host = detect_busy ? src_wd[`CCR_POS_ILIM_HI:`CCR_POS_ILIM_LO] :
	                       shift_r[`CCR_POS_ILIM_HI:`CCR_POS_ILIM_LO];
	wire [7:0] src_hw  = wr_src ? {shift_r[7:5], ilim_host} : src_wd;
	wire [7:0] chg_hw  = wr_chg ? shift_r : chg_kc; // A write of 1 beats the self-clear
	wire [7:0] cur_hw  = wr_cur ? shift_r : cur_wd;

	// Detection result wins over a host write in the same cycle
	wire [7:0] src_nxt = detect_done ? {src_hw[7:5], detect_limit} : src_hw;
	wire [7:0] chg_nxt = chg_hw;
	wire [7:0] cur_nxt = cur_hw;

	// Restart request on any write that sets the kick bit
	wire restart_nxt = wr_chg & shift_r[`CCR_BIT_KICK];

	// Register file; register-reset returns every field
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			src_r <= `CCR_POWER_ON_VALUE_INPUT_SRC;
			chg_r <= `CCR_POWER_ON_VALUE_CHG_EN;
			cur_r <= `CCR_POWER_ON_VALUE_CHG_CUR;
		end
		else if (reg_reset_cmd)
		begin
			src_r <= `CCR_POWER_ON_VALUE_INPUT_SRC;
			chg_r <= `CCR_POWER_ON_VALUE_CHG_EN;
			cur_r <= `CCR_POWER_ON_VALUE_CHG_CUR;
		end
		else
		begin
			src_r <= src_nxt;
			chg_r <= chg_nxt;
			cur_r <= cur_nxt;
		end
	end

	// Watchdog restart pulse, one cycle per kick
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			watchdog_restart <= 1'b0;
		else
			watchdog_restart <= restart_nxt & ~reg_reset_cmd;
	end

	// Slave state transitions; start and stop override everything
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ccr_pkg::ST_IDLE:
				state_nxt = ccr_pkg::ST_IDLE;
			ccr_pkg::ST_ADDR:
				if (byte_done)
					state_nxt = addr_hit ? ccr_pkg::ST_ADDR_ACK : ccr_pkg::ST_IDLE;
			ccr_pkg::ST_ADDR_ACK:
				if (bus.scl_fall)
					state_nxt = rw_r ? ccr_pkg::ST_RDATA : ccr_pkg::ST_REG;
			ccr_pkg::ST_REG:
				if (byte_done)
					state_nxt = ccr_pkg::ST_REG_ACK;
			ccr_pkg::ST_REG_ACK:
				if (bus.scl_fall)
					state_nxt = ccr_pkg::ST_WDATA;
			ccr_pkg::ST_WDATA:
				if (byte_done)
					state_nxt = ccr_pkg::ST_WACK;
			ccr_pkg::ST_WACK:
				if (bus.scl_fall)
					state_nxt = ccr_pkg::ST_WDATA;
			ccr_pkg::ST_RDATA:
				if (byte_done)
					state_nxt = ccr_pkg::ST_RACK;
			ccr_pkg::ST_RACK:
				if (bus.scl_rise && bus.sda)
					state_nxt = ccr_pkg::ST_IDLE; // Refusal ends the read
				else if (bus.scl_fall)
					state_nxt = ccr_pkg::ST_RDATA;
			default:
				state_nxt = ccr_pkg::ST_IDLE;
		endcase
		if (bus.stop)
			state_nxt = ccr_pkg::ST_IDLE;
		if (bus.start)
			state_nxt = ccr_pkg::ST_ADDR;
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_r <= ccr_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Bit counter; restarts on start and at each new byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bit_cnt_r <= 4'h0;
		else if (bus.start || (bus.scl_fall && state_r != state_nxt))
			bit_cnt_r <= 4'h0;
		else if (bus.scl_rise && bit_cnt_r != 4'h8)
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end

	// Receive shifter, most significant bit first
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			shift_r <= 8'h00;
		else if (in_rx && bus.scl_rise && bit_cnt_r != 4'h8)
			shift_r <= {shift_r[6:0], bus.sda};
	end

	// Direction latched with the address byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rw_r <= 1'b0;
		else if (state_r == ccr_pkg::ST_ADDR && byte_done)
			rw_r <= shift_r[0];
	end

	// Pointer: loaded by the register byte, stepped after each written or acknowledged read byte
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ptr_r <= 8'h00;
		else if (state_r == ccr_pkg::ST_REG && byte_done)
			ptr_r <= shift_r;
		else if (wr_stb || rack_ok)
			ptr_r <= next_ptr(ptr_r);
	end

	// Transmit shifter; a byte is loaded as the data phase begins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tx_r <= 8'h00;
		else if (bus.scl_fall && state_nxt == ccr_pkg::ST_RDATA && state_r != ccr_pkg::ST_RDATA)
			tx_r <= rd_byte;
		else if (bus.scl_fall && state_r == ccr_pkg::ST_RDATA)
			tx_r <= {tx_r[6:0], 1'b1};
	end

	// Data line pull-down: acknowledge, or a zero data bit
	always_comb
	begin
		sda_oe_nxt = sda_oe;
		if (bus.scl_fall)
		begin
			case (state_nxt)
				ccr_pkg::ST_ADDR_ACK,
				ccr_pkg::ST_REG_ACK,
				ccr_pkg::ST_WACK:
					sda_oe_nxt = 1'b1;
				ccr_pkg::ST_RDATA:
					if (state_r == ccr_pkg::ST_RDATA)
						sda_oe_nxt = ~tx_r[6];
					else
						sda_oe_nxt = ~rd_byte[7];
				default:
					sda_oe_nxt = 1'b0;
			endcase
		end
		if (bus.start || bus.stop || state_nxt == ccr_pkg::ST_IDLE)
			sda_oe_nxt = 1'b0;
	end

	// Pin flops; the line is only ever pulled low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end
		else
		begin
			sda_oe <= sda_oe_nxt;
			sda_o  <= 1'b0;
		end
	end

	// Enable pin synchroniser; only the second stage is used
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ce_sy_r <= 2'h3;
		else
			ce_sy_r <= {ce_sy_r[0], charge_enable_pin_low_n};
	end

	// Decoded settings
	wire       boost_w  = chg_r[`CCR_BIT_BOOST];
	wire       charge_w = chg_r[`CCR_BIT_CHG] & ~ce_sy_r[1] & ~boost_w;
	wire [4:0] ilim_w   = src_r[`CCR_POS_ILIM_HI:`CCR_POS_ILIM_LO];
	wire       fulldrv_w = boost_w | cur_r[`CCR_BIT_FULLDRV] |
	                       (ilim_w >= `CCR_ILIM_FULL_CODE);

	// Settings register; one cycle behind the register file
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_o <= '0;
		else
		begin
			ctrl_o.input_float_mode         <= src_r[`CCR_BIT_FLOAT];
			ctrl_o.indicator_pin_function   <= src_r[`CCR_POS_IND_HI:`CCR_POS_IND_LO];
			ctrl_o.input_current_limit      <= ilim_w;
			ctrl_o.light_load_mod_disable   <= chg_r[`CCR_BIT_LLM_DIS];
			ctrl_o.boost_output_enable      <= boost_w;
			ctrl_o.charge_active            <= charge_w;
			ctrl_o.system_voltage_floor     <= chg_r[`CCR_POS_SYSV_HI:`CCR_POS_SYSV_LO];
			ctrl_o.boost_low_battery_select <= chg_r[`CCR_BIT_LOWBAT];
			ctrl_o.boost_current_limit      <= cur_r[`CCR_BIT_BLIM];
			ctrl_o.input_switch_full_drive  <= fulldrv_w;
			ctrl_o.fast_charge_current_ma   <= fast_charge_current_code_ma(cur_r[`CCR_POS_FAST_CHARGE_CURRENT_CODE_HI:`CCR_POS_FAST_CHARGE_CURRENT_CODE_LO]);
		end
	end

endmodule : ccr_bank

// ---- tb/ccr_bank_assertions.sv ----
// Port checks for the charger configuration register bank.
// Bound into ccr_bank; sees only its ports.
`timescale 1ns/1ns

module ccr_bank_assertions (
	// Clock and reset
	input wire logic          clk,
	input wire logic          rst,
	// Serial pins
	input wire logic          scl_i,
	input wire logic          sda_o,
	input wire logic          sda_oe,
	// Side inputs
	input wire logic          charge_enable_pin_low_n,
	input wire logic          detect_done,
	input wire logic [4:0]    detect_limit,
	input wire logic          watchdog_expired,
	input wire logic          reg_reset_cmd,
	// Outputs watched
	input wire logic          watchdog_restart,
	input ccr_pkg::ccr_ctrl_s ctrl_o
);
	// Decoded power-on settings seen on the outputs
	wire power_on_value_ok = ctrl_o.input_float_mode == 1'b0 && ctrl_o.indicator_pin_function == 2'h0
		&& ctrl_o.input_current_limit == 5'h17 && ctrl_o.light_load_mod_disable == 1'b0
		&& ctrl_o.system_voltage_floor == 3'h5 && ctrl_o.boost_current_limit == 1'b1
		&& ctrl_o.fast_charge_current_ma == 12'h7bc && ctrl_o.boost_output_enable == 1'b0;
	// Only the watchdog subset is pinned after expiry
	wire wdog_ok = !ctrl_o.input_float_mode && !ctrl_o.boost_output_enable
		&& ctrl_o.boost_current_limit && ctrl_o.fast_charge_current_ma == 12'h7bc;

	// One clock domain, so one default for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_SDA_LOW: assert property (!sda_o)
		else $error("data output not held low");
	AST_DRIVE_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_i)
		else $error("data line taken while clock high");
	AST_POWER_ON_VALUE: assert property ($fell(rst) |=> power_on_value_ok)
		else $error("power-on settings wrong");
	AST_REG_RESET: assert property (reg_reset_cmd |-> ##2 power_on_value_ok)
		else $error("register reset left a field");
	AST_WDOG: assert property (watchdog_expired && !reg_reset_cmd |-> ##2 wdog_ok)
		else $error("watchdog subset not restored");
	AST_DETECT: assert property (detect_done && !reg_reset_cmd |-> ##2
		ctrl_o.input_current_limit == $past(detect_limit, 2))
		else $error("detected limit not loaded");
	AST_BOOST_PRIO: assert property (ctrl_o.boost_output_enable |-> !ctrl_o.charge_active)
		else $error("charging while boost enabled");
	AST_PIN_HIGH: assert property (charge_enable_pin_low_n [*5] |-> !ctrl_o.charge_active)
		else $error("charging with pin high");
	AST_FULL_DRIVE: assert property ((ctrl_o.boost_output_enable
		|| ctrl_o.input_current_limit >= 5'h06) |-> ctrl_o.input_switch_full_drive)
		else $error("switch not at full drive");
	AST_FAST_CHARGE_CURRENT_CODE_CAP: assert property (ctrl_o.fast_charge_current_ma <= 12'hbb8)
		else $error("charge current above 3000 mA");
	AST_KICK_PULSE: assert property (watchdog_restart |=> !watchdog_restart)
		else $error("restart pulse too long");
endmodule : ccr_bank_assertions

bind ccr_bank ccr_bank_assertions i_ccr_bank_assertions (.clk(clk), .rst(rst),
	.scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.charge_enable_pin_low_n(charge_enable_pin_low_n), .detect_done(detect_done),
	.detect_limit(detect_limit), .watchdog_expired(watchdog_expired),
	.reg_reset_cmd(reg_reset_cmd), .watchdog_restart(watchdog_restart), .ctrl_o(ctrl_o));

// ---- tb/ccr_i2c_host.sv ----
// Serial bus master model for the register bank.
// Assumes the bench resolves the pulled-up data line.
`timescale 1ns/1ns

module ccr_i2c_host (
	// Bit timing clock
	input wire logic clk,
	// Resolved data line
	input wire logic sda,
	// Master pins
	output logic     scl,
	output logic     sda_pull
);
	// Bus starts free, both lines released
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// Wait clocks, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick
	// Start or repeated start; clock left low
	task automatic start();
		sda_pull = 1'b0;
		// Slave lets go of the ack about four clocks after the fall; wait past that
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask : start
	// Stop, data rises with clock high
	task automatic stop();
		tick(4);
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask : stop
	// One bit; data moves only with clock low, 8 clk low and high
	task automatic bit1(input logic b, output logic r);
		tick(4);
		sda_pull = !b;
		tick(4);
		scl = 1'b1;
		tick(4);
		r = sda;
		tick(4);
		scl = 1'b0;
	endtask : bit1
	// Byte MSB first, then the ninth bit
	task automatic xfer(input logic [7:0] tx, input logic tx9, output logic [7:0] rx,
		output logic rx9);
		for (int i = 7; i >= 0; i--)
			bit1(tx[i], rx[i]);
		bit1(tx9, rx9);
	endtask : xfer
endmodule : ccr_i2c_host

// ---- tb/tb_top.sv ----
// Self-checking bench for the register bank.
// Drives the bus through the master model; side inputs direct.
`timescale 1ns/1ns

module tb_top;
	logic               clk, rst, scl, sda_pull, sda_line, sda_o, sda_oe;
	logic               pin_n, busy, done, wd_exp, rr, watchdog_kick;
	logic [4:0]         lim;
	logic [23:0]        q;
	ccr_pkg::ccr_ctrl_s ctrl;
	int                 n_errors, checked, kicks;
	// Charge current table samples
	logic [5:0]  codes [6] = '{6'h00, 6'h08, 6'h10, 6'h20, 6'h30, 6'h3f};
	logic [11:0] mas [6] = '{12'h000, 12'h028, 12'h082, 12'h21c, 12'h5dc, 12'hbb8};

	// Open-drain line with pull-up
	assign sda_line = !(sda_pull || (sda_oe && !sda_o));
	ccr_i2c_host i_ccr_i2c_host (.clk(clk), .sda(sda_line), .scl(scl), .sda_pull(sda_pull));
	ccr_bank i_ccr_bank (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe(sda_oe), .charge_enable_pin_low_n(pin_n), .detect_busy(busy),
		.detect_done(done), .detect_limit(lim), .watchdog_expired(wd_exp),
		.reg_reset_cmd(rr), .watchdog_restart(watchdog_kick), .ctrl_o(ctrl));

	// 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end
	// Restart pulses counted as they pass
	always @(posedge clk)
		if (watchdog_kick === 1'b1)
			kicks <= kicks + 1;

	task automatic chk(input logic [28:0] seen, input logic [28:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// Expected settings worked out from register bytes
	function automatic logic [28:0] ctl(input logic [7:0] r0, r1, r2, input logic pn,
		input logic [11:0] ma);
		ctl = {r0, r1[7], r1[5], r1[4] & !pn & !r1[5], r1[3:0], r2[7],
			r1[5] | r2[6] | (r0[4:0] >= 5'h06), ma};
	endfunction : ctl
	// Byte out, acknowledge expected
	task automatic send(input logic [7:0] b);
		logic [7:0] rx;
		logic       ak;
		i_ccr_i2c_host.xfer(b, 1'b1, rx, ak);
		chk({28'h0, ak}, 29'h0);
	endtask : send
	task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
		i_ccr_i2c_host.start();
		send({7'h1a, 1'b0});
		send(a);
		for (int i = 0; i < n; i++)
			send(d[23 - 8 * i -: 8]);
		i_ccr_i2c_host.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, input int n, output logic [23:0] d);
		logic [7:0] rx;
		logic       ak;
		d = 24'h0;
		i_ccr_i2c_host.start();
		send({7'h1a, 1'b0});
		send(a);
		i_ccr_i2c_host.start();
		send({7'h1a, 1'b1});
		for (int i = 0; i < n; i++)
		begin
			i_ccr_i2c_host.xfer(8'hff, i == n - 1, rx, ak);
			d[23 - 8 * i -: 8] = rx;
		end
		i_ccr_i2c_host.stop();
	endtask : rd
	// One-clock side pulse: 0 done, 1 expiry, 2 register reset
	task automatic pulse(input int k);
		@(posedge clk);
		#5 {done, wd_exp, rr} = 3'h4 >> k;
		@(posedge clk);
		#5 {done, wd_exp, rr} = 3'h0;
	endtask : pulse

	task automatic t_power_on_value();
		rd(8'h00, 3, q);
		chk({5'h0, q}, {5'h0, 24'h171ab4});
		chk(ctrl, ctl(8'h17, 8'h1a, 8'hb4, pin_n, 12'h7bc));
		$display("power-on test done");
	endtask : t_power_on_value
	task automatic t_detect();
		busy = 1'b1;
		wr(8'h00, 24'h050000, 1);
		rd(8'h00, 1, q);
		chk({5'h0, q}, {5'h0, 24'h170000});
		lim = 5'h0a;
		pulse(0);
		busy = 1'b0;
		rd(8'h00, 1, q);
		chk({5'h0, q}, {5'h0, 24'h0a0000});
		wr(8'h00, 24'h090000, 1);
		rd(8'h00, 1, q);
		chk({5'h0, q}, {5'h0, 24'h090000});
		$display("detection test done");
	endtask : t_detect
	task automatic t_fields();
		wr(8'h00, 24'ha3be3d, 3);
		rd(8'h00, 3, q);
		chk({5'h0, q}, {5'h0, 24'ha3be3d});
		chk(ctrl, ctl(8'ha3, 8'hbe, 8'h3d, pin_n, 12'hbb8));
		pin_n = 1'b0;
		wr(8'h01, 24'h100000, 1);
		chk(ctrl, ctl(8'ha3, 8'h10, 8'h3d, 1'b0, 12'hbb8));
		pin_n = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h02, {2'h2, codes[i], 16'h0}, 1);
			chk({17'h0, ctrl.fast_charge_current_ma}, {17'h0, mas[i]});
		end
		$display("field test done");
	endtask : t_fields
	task automatic t_kick();
		wr(8'h01, 24'h400000, 1);
		chk(29'(kicks), 29'h1);
		rd(8'h01, 1, q);
		chk({5'h0, q}, 29'h0);
		$display("kick test done");
	endtask : t_kick
	task automatic t_wdog();
		wr(8'h00, 24'hffaf7f, 3);
		pulse(1);
		rd(8'h00, 3, q);
		chk({5'h0, q}, {5'h0, 24'h7f9ff4});
		pulse(2);
		rd(8'h00, 3, q);
		chk({5'h0, q}, {5'h0, 24'h171ab4});
		$display("watchdog test done");
	endtask : t_wdog
	task automatic t_map();
		logic [7:0] rx;
		logic       ak;
		rd(8'h0d, 3, q);
		chk({5'h0, q}, {5'h0, 24'h0000ff});
		rd(8'h10, 1, q);
		chk({5'h0, q}, {5'h0, 24'hff0000});
		i_ccr_i2c_host.start();
		i_ccr_i2c_host.xfer({7'h1b, 1'b0}, 1'b1, rx, ak);
		chk({28'h0, ak}, 29'h1);
		i_ccr_i2c_host.stop();
		$display("map test done");
	endtask : t_map

	// Bound on the whole run
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		{rst, pin_n} = 2'h3;
		{busy, done, wd_exp, rr, lim} = 9'h0;
		{n_errors, checked} = {32'h0, 32'h0};
		repeat (20) @(posedge clk);
		#5 rst = 1'b0;
		repeat (8) @(posedge clk);
		t_power_on_value();
		t_detect();
		t_fields();
		t_kick();
		t_wdog();
		t_map();
		end_sim();
	end
endmodule : tb_top
